// ===== logic/dram_io_cfg.svh
// Constants of the dual-rank DDR2 ball interface: widths, mode bit positions, reset values
`ifndef DRAM_IO_CFG_SVH
`define DRAM_IO_CFG_SVH

// ==========================================================
// Widths
`define RANKS 2
`define BEAT_W 8
`define BEATS 4
`define CORE_W 32
`define ADDR_W 14
`define BA_W 3
`define PEND_W 3
`define CTL_W 26
`define PIN_W 3

// ==========================================================
// Extended mode register selection and field positions
`define BA_EMR 3'h1
`define EMR_RTT_LO 2
`define EMR_RTT_HI 6
`define EMR_DQSC_DIS 10
`define EMR_RDQS_EN 11

// ==========================================================
// Read buffer and reset values
`define RD_FIFO_DEPTH 32
`define PEND_MAX 3'h7
`define LAST_BEAT 2'h3
`define OE_OFF 8'hff
`define OE_X8 8'h00
`define OE_X4 8'hf0
`define TERM_X8 8'hff
`define TERM_X4 8'h0f

`endif

// ===== logic/dram_io_pkg.sv
// Types shared by the dual-rank DDR2 ball interface
package dram_io_pkg;
	`include "dram_io_cfg.svh"

	// ==========================================================
	// Command code taken from RAS#, CAS#, WE# in that order
	typedef enum logic [2:0] {
		CMD_LOAD_MODE = 3'h0,
		CMD_REFRESH = 3'h1,
		CMD_PRECHARGE = 3'h2,
		CMD_ACTIVATE = 3'h3,
		CMD_WRITE = 3'h4,
		CMD_READ = 3'h5,
		CMD_TERMINATE = 3'h6,
		CMD_NOP = 3'h7
	} cmd_e;

	// Read burst sequencer
	typedef enum logic [1:0] {
		RD_IDLE = 2'b01,
		RD_BURST = 2'b10
	} rd_state_e;

	typedef logic [`CORE_W-1:0] core_word_t;

	// ==========================================================
	// State of the interface, apart from the read buffer and the o_rd_ready register
	typedef struct packed {
		logic [1:0] ck_s1;
		logic [1:0] ck_s2;
		logic ck_prev;
		logic [`CTL_W-1:0] ctl_s1;
		logic [`CTL_W-1:0] ctl_s2;
		logic [`BEAT_W-1:0] dq_s1;
		logic [`BEAT_W-1:0] dq_s2;
		logic [`PIN_W-1:0] pin_s1;
		logic [`PIN_W-1:0] pin_s2;
		logic dqs_prev;
		logic [`RANKS-1:0] cke_q;
		logic [`RANKS-1:0] odt_q;
		logic [`RANKS-1:0] rtt_en;
		logic [`RANKS-1:0] dqsc_dis;
		logic [`RANKS-1:0] rdqs_en;
		logic [`PEND_W-1:0] wr_pend;
		logic [1:0] wr_beat;
		core_word_t wr_word;
		logic [`BEATS-1:0] wr_mask;
		logic wr_rank;
		logic [`PEND_W-1:0] rd_pend;
		logic [1:0] rd_beat;
		core_word_t rd_word;
		logic rd_rank;
		rd_state_e state;
		logic [`BEAT_W-1:0] dq;
		logic [`BEAT_W-1:0] dq_oe_n;
		logic dqs;
		logic dqs_oe_n;
		logic dqs_c;
		logic dqs_c_oe_n;
		logic rdqs;
		logic rdqs_oe_n;
		logic rdqs_c;
		logic rdqs_c_oe_n;
		logic [`RANKS-1:0] term_rank;
		logic [`BEAT_W-1:0] term_dq;
		logic term_dqs;
		logic term_dqs_c;
		logic term_dm;
		logic cmd_valid;
		cmd_e cmd_code;
		logic cmd_rank;
		logic [`BA_W-1:0] cmd_bank;
		logic [`ADDR_W-1:0] cmd_addr;
		logic wr_valid;
		core_word_t wr_data;
		logic [`BEATS-1:0] wr_mask_out;
		logic wr_rank_out;
	} io_state_s;
endpackage : dram_io_pkg

// ===== logic/rd_word_fifo.sv
// Flip-flop FIFO holding core read words on their way to the ball side
`timescale 1ns/1ps
module rd_word_fifo #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 32
) (
	input wire logic i_clk, // System clock
	input wire logic i_sys_rst, // Synchronous reset, active high
	input wire logic i_in_valid, // Word offered
	input wire logic [WIDTH-1:0] i_in_data, // Word offered
	output logic o_in_ready, // Room for a word
	output logic o_out_valid, // Word available
	output logic [WIDTH-1:0] o_out_data, // Oldest word
	input wire logic i_out_ready // Drain takes the word
);
	localparam int PW = $clog2(DEPTH);
	localparam int CW = PW + 1;

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [PW-1:0] wr_ptr;
		logic [PW-1:0] rd_ptr;
		logic [CW-1:0] count;
		logic in_ready;
		logic out_valid;
	} fifo_state_s;

	fifo_state_s s_q;
	fifo_state_s s_d;
	logic push;
	logic pop;

	// ==========================================================
	// Next state; flags are registered from the next count so they never lie
	always_comb begin
		s_d = s_q;
		push = i_in_valid & s_q.in_ready;
		pop = i_out_ready & s_q.out_valid;
		if (push) begin
			s_d.mem[s_q.wr_ptr] = i_in_data;
			s_d.wr_ptr = s_q.wr_ptr + 1'b1;
		end
		if (pop) begin
			s_d.rd_ptr = s_q.rd_ptr + 1'b1;
		end
		s_d.count = s_q.count + CW'(push) - CW'(pop);
		s_d.in_ready = s_d.count != CW'(DEPTH);
		s_d.out_valid = s_d.count != '0;
		if (i_sys_rst) begin
			s_d = '0;
			s_d.in_ready = 1'b1;
		end
	end

	// State register
	always_ff @(posedge i_clk) begin
		s_q <= s_d;
	end

	assign o_in_ready = s_q.in_ready;
	assign o_out_valid = s_q.out_valid;
	assign o_out_data = s_q.mem[s_q.rd_ptr];
endmodule : rd_word_fifo

// ===== logic/dram_io_if.sv
// Ball-level command, termination and data/strobe logic of a two-rank DDR2 device
`timescale 1ns/1ps
module dram_io_if (
	input wire logic i_clk, // System clock, 200 MHz
	input wire logic i_sys_rst, // Synchronous reset, active high
	input wire logic i_org_x8, // Organization strap: 1 x8, 0 x4
	input wire logic i_ck, // Link clock true
	input wire logic i_ck_c, // Link clock complement
	input wire logic [1:0] i_cs_n, // Chip select per rank
	input wire logic [1:0] i_cke, // Clock enable per rank
	input wire logic [1:0] i_odt, // Termination enable per rank
	input wire logic i_ras_n, // Row strobe
	input wire logic i_cas_n, // Column strobe
	input wire logic i_we_n, // Write enable
	input wire logic [2:0] i_ba, // Bank address
	input wire logic [13:0] i_addr, // Row / column address
	input wire logic [7:0] i_dq, // Data ball level
	output logic [7:0] o_dq, // Data ball drive
	output logic [7:0] o_dq_oe_n, // Data drive enable, low drives
	input wire logic i_dqs, // Strobe ball level
	output logic o_dqs, // Strobe drive
	output logic o_dqs_oe_n, // Strobe drive enable, low drives
	output logic o_dqs_c, // Complement strobe drive
	output logic o_dqs_c_oe_n, // Complement strobe enable, low drives
	input wire logic i_dm_rdqs, // Shared mask / redundant strobe ball level
	output logic o_rdqs, // Redundant strobe drive
	output logic o_rdqs_oe_n, // Redundant strobe enable, low drives
	output logic o_rdqs_c, // Complement redundant strobe drive
	output logic o_rdqs_c_oe_n, // Complement redundant strobe enable, low drives
	output logic [1:0] o_term_rank, // Termination active per rank
	output logic [7:0] o_term_dq, // Termination on data balls
	output logic o_term_dqs, // Termination on strobe
	output logic o_term_dqs_c, // Termination on complement strobe
	output logic o_term_dm, // Termination on mask ball
	output logic [1:0] o_rank_active, // Rank circuitry enabled
	output logic o_cmd_valid, // Decoded command pulse
	output dram_io_pkg::cmd_e o_cmd_code, // Decoded command
	output logic o_cmd_rank, // Target rank
	output logic [2:0] o_cmd_bank, // Target bank
	output logic [13:0] o_cmd_addr, // Address with command
	output logic o_wr_valid, // Write core word pulse
	output logic [31:0] o_wr_data, // Write core word
	output logic [3:0] o_wr_mask, // Per-beat discard flags
	output logic o_wr_rank, // Rank of write word
	input wire logic i_rd_valid, // Read core word offered
	input wire logic [31:0] i_rd_data, // Read core word
	output logic o_rd_ready // Read buffer has room
);
	import dram_io_pkg::*;

	io_state_s s_q;
	io_state_s n;
	logic fifo_valid;
	logic fifo_ready;
	logic fifo_pop;
	core_word_t fifo_data;

	// ==========================================================
	// Functions
	// Saturating pending counter update
	function automatic logic [`PEND_W-1:0] pend_next(input logic [`PEND_W-1:0] p, input logic inc,
		input logic dec);
		logic [`PEND_W-1:0] r;
		r = p;
		if (inc && !dec && p != `PEND_MAX) begin
			r = p + 1'b1;
		end else if (dec && !inc && p != '0) begin
			r = p - 1'b1;
		end
		return r;
	endfunction : pend_next

	// Beat k of a core word; x4 words fill only the low half
	function automatic logic [`BEAT_W-1:0] beat_of(input core_word_t w, input logic [1:0] k, input logic x8);
		logic [`BEAT_W-1:0] r;
		r = x8 ? w[8*k +: 8] : {4'h0, w[4*k +: 4]};
		return r;
	endfunction : beat_of

	// ==========================================================
	// Read buffer; back-pressure reaches the core side through o_rd_ready
	rd_word_fifo #(
		.WIDTH(`CORE_W),
		.DEPTH(`RD_FIFO_DEPTH)
	) u_rd_fifo (
		.i_clk(i_clk),
		.i_sys_rst(i_sys_rst),
		.i_in_valid(i_rd_valid),
		.i_in_data(i_rd_data),
		.o_in_ready(fifo_ready),
		.o_out_valid(fifo_valid),
		.o_out_data(fifo_data),
		.i_out_ready(fifo_pop)
	);

	// ==========================================================
	// Next-state logic
	always_comb begin
		logic ck_lvl;
		logic ck_rise;
		logic ck_fall;
		logic [1:0] cs_n;
		logic [1:0] cke;
		logic [1:0] odt;
		cmd_e cmd;
		logic [`BA_W-1:0] ba;
		logic [`ADDR_W-1:0] addr;
		logic x8;
		logic dqs_lvl;
		logic dm;
		logic dqs_edge;
		logic sel;
		logic hit;
		logic wr_inc;
		logic wr_dec;
		logic rd_inc;
		logic rd_dec;
		logic dm_mode;
		logic [1:0] k;
		n = s_q;
		fifo_pop = 1'b0;
		wr_inc = 1'b0;
		wr_dec = 1'b0;
		rd_inc = 1'b0;
		rd_dec = 1'b0;
		k = 2'h0;
		n.cmd_valid = 1'b0;
		n.wr_valid = 1'b0;
		// Two-flop synchronisers; logic reads only the second stage
		n.ck_s1 = {i_ck_c, i_ck};
		n.ck_s2 = s_q.ck_s1;
		n.ctl_s1 = {i_cs_n, i_cke, i_odt, i_ras_n, i_cas_n, i_we_n, i_ba, i_addr};
		n.ctl_s2 = s_q.ctl_s1;
		n.dq_s1 = i_dq;
		n.dq_s2 = s_q.dq_s1;
		n.pin_s1 = {i_org_x8, i_dm_rdqs, i_dqs};
		n.pin_s2 = s_q.pin_s1;
		// Clock crossing: high while CK high and CK# low
		ck_lvl = s_q.ck_s2[0] & ~s_q.ck_s2[1];
		n.ck_prev = ck_lvl;
		ck_rise = ck_lvl & ~s_q.ck_prev;
		ck_fall = ~ck_lvl & s_q.ck_prev;
		cs_n = s_q.ctl_s2[25:24];
		cke = s_q.ctl_s2[23:22];
		odt = s_q.ctl_s2[21:20];
		cmd = cmd_e'(s_q.ctl_s2[19:17]);
		ba = s_q.ctl_s2[16:14];
		addr = s_q.ctl_s2[13:0];
		x8 = s_q.pin_s2[2];
		dm = s_q.pin_s2[1];
		dqs_lvl = s_q.pin_s2[0];
		n.dqs_prev = dqs_lvl;
		dqs_edge = dqs_lvl ^ s_q.dqs_prev;

		// Command decode at each rising crossing; a low select picks its die, rank 0 when both are low
		sel = cs_n[0];
		hit = ~&cs_n && cke[sel];
		if (ck_rise) begin
			n.cke_q = cke;
			n.odt_q = odt;
			if (hit) begin
				n.cmd_valid = 1'b1;
				n.cmd_code = cmd;
				n.cmd_rank = sel;
				n.cmd_bank = ba;
				n.cmd_addr = addr;
				// Each die keeps its own mode bits, so ranks are independent
				if (cmd == CMD_LOAD_MODE && ba == `BA_EMR) begin
					n.rtt_en[sel] = addr[`EMR_RTT_LO] | addr[`EMR_RTT_HI];
					n.dqsc_dis[sel] = addr[`EMR_DQSC_DIS];
					n.rdqs_en[sel] = addr[`EMR_RDQS_EN];
				end
				if (cmd == CMD_WRITE) begin
					wr_inc = 1'b1;
					n.wr_rank = sel;
				end
				if (cmd == CMD_READ) begin
					rd_inc = 1'b1;
					n.rd_rank = sel;
				end
			end
		end

		// Write capture on both strobe edges; the strobe is centred in each bit, so sampling is at its edge
		dm_mode = ~(x8 & s_q.rdqs_en[s_q.wr_rank]);
		if (dqs_edge && s_q.wr_pend != '0 && s_q.state == RD_IDLE) begin
			k = s_q.wr_beat;
			if (x8) begin
				n.wr_word[8*k +: 8] = s_q.dq_s2;
			end else begin
				n.wr_word[4*k +: 4] = s_q.dq_s2[3:0];
				n.wr_word[16 + 4*k +: 4] = 4'h0;
			end
			n.wr_mask[k] = dm_mode & dm;
			n.wr_beat = s_q.wr_beat + 2'h1;
			if (s_q.wr_beat == `LAST_BEAT) begin
				n.wr_valid = 1'b1;
				n.wr_data = n.wr_word;
				n.wr_mask_out = n.wr_mask;
				n.wr_rank_out = s_q.wr_rank;
				wr_dec = 1'b1;
			end
		end

		// Read bursts: one beat per clock half, strobe toggling with the data
		unique case (s_q.state)
			RD_IDLE: begin
				if (ck_rise && s_q.rd_pend != '0 && fifo_valid) begin
					fifo_pop = 1'b1;
					rd_dec = 1'b1;
					n.rd_word = fifo_data;
					n.rd_beat = 2'h0;
					n.state = RD_BURST;
					n.dq = beat_of(fifo_data, 2'h0, x8);
					n.dq_oe_n = x8 ? `OE_X8 : `OE_X4;
					n.dqs = 1'b1;
					n.dqs_oe_n = 1'b0;
				end
			end
			RD_BURST: begin
				if (ck_rise || ck_fall) begin
					if (s_q.rd_beat == `LAST_BEAT) begin
						n.state = RD_IDLE;
						n.dq_oe_n = `OE_OFF;
						n.dqs = 1'b0;
						n.dqs_oe_n = 1'b1;
					end else begin
						n.rd_beat = s_q.rd_beat + 2'h1;
						n.dq = beat_of(s_q.rd_word, n.rd_beat, x8);
						n.dqs = ~s_q.dqs;
					end
				end
			end
		endcase
		n.wr_pend = pend_next(s_q.wr_pend, wr_inc, wr_dec);
		n.rd_pend = pend_next(s_q.rd_pend, rd_inc, rd_dec);

		// Companion strobes follow the main strobe under the read rank's mode bits
		n.dqs_c = ~n.dqs;
		n.dqs_c_oe_n = n.dqs_oe_n | s_q.dqsc_dis[n.rd_rank];
		n.rdqs = n.dqs;
		n.rdqs_oe_n = n.dqs_oe_n | ~(x8 & s_q.rdqs_en[n.rd_rank]);
		n.rdqs_c = ~n.dqs;
		n.rdqs_c_oe_n = n.rdqs_oe_n | s_q.dqsc_dis[n.rd_rank];

		// Termination: registered request gated by the die's own enable
		n.term_rank = s_q.odt_q & s_q.rtt_en;
		n.term_dq = (|n.term_rank) ? (x8 ? `TERM_X8 : `TERM_X4) : 8'h00;
		n.term_dqs = |n.term_rank;
		n.term_dqs_c = |(n.term_rank & ~s_q.dqsc_dis);
		n.term_dm = |(n.term_rank & ~(s_q.rdqs_en & {2{x8}}));

		// Synchronous reset: pins released, modes cleared
		if (i_sys_rst) begin
			n = '0;
			n.state = RD_IDLE;
			n.cmd_code = CMD_NOP;
			// Link clock history starts at the crossing-high level, so release can only show a harmless fall
			n.ck_s1 = 2'b01;
			n.ck_s2 = 2'b01;
			n.ck_prev = 1'b1;
			n.dq_oe_n = `OE_OFF;
			n.dqs_oe_n = 1'b1;
			n.dqs_c = 1'b1;
			n.dqs_c_oe_n = 1'b1;
			n.rdqs_c = 1'b1;
			n.rdqs_oe_n = 1'b1;
			n.rdqs_c_oe_n = 1'b1;
		end
	end

	// ==========================================================
	// State register, plus the buffer's room flag re-timed for the port
	always_ff @(posedge i_clk) begin
		s_q <= n;
		o_rd_ready <= fifo_ready & ~i_sys_rst;
	end

	// Outputs straight from the state register
	assign o_dq = s_q.dq;
	assign o_dq_oe_n = s_q.dq_oe_n;
	assign o_dqs = s_q.dqs;
	assign o_dqs_oe_n = s_q.dqs_oe_n;
	assign o_dqs_c = s_q.dqs_c;
	assign o_dqs_c_oe_n = s_q.dqs_c_oe_n;
	assign o_rdqs = s_q.rdqs;
	assign o_rdqs_oe_n = s_q.rdqs_oe_n;
	assign o_rdqs_c = s_q.rdqs_c;
	assign o_rdqs_c_oe_n = s_q.rdqs_c_oe_n;
	assign o_term_rank = s_q.term_rank;
	assign o_term_dq = s_q.term_dq;
	assign o_term_dqs = s_q.term_dqs;
	assign o_term_dqs_c = s_q.term_dqs_c;
	assign o_term_dm = s_q.term_dm;
	assign o_rank_active = s_q.cke_q;
	assign o_cmd_valid = s_q.cmd_valid;
	assign o_cmd_code = s_q.cmd_code;
	assign o_cmd_rank = s_q.cmd_rank;
	assign o_cmd_bank = s_q.cmd_bank;
	assign o_cmd_addr = s_q.cmd_addr;
	assign o_wr_valid = s_q.wr_valid;
	assign o_wr_data = s_q.wr_data;
	assign o_wr_mask = s_q.wr_mask_out;
	assign o_wr_rank = s_q.wr_rank_out;
endmodule : dram_io_if

// ===== tb/dram_io_checker.sv
// Concurrent checks on the ports of the dual-rank DDR2 ball interface
`timescale 1ns/1ps
`include "dram_io_cfg.svh"
module dram_io_checker (
	input wire logic i_clk, i_sys_rst, i_org_x8, i_ck, i_ras_n, i_cas_n, i_we_n, // Clock, reset, strap, link
	input wire logic [1:0] i_cs_n, i_cke, i_odt, o_term_rank, // Per-rank controls
	input wire logic [2:0] i_ba, o_cmd_bank, // Bank in and out
	input wire logic [13:0] i_addr, o_cmd_addr, // Address in and out
	input wire logic [7:0] o_dq, o_dq_oe_n, o_term_dq, // Data drive and termination
	input wire logic o_dqs, o_dqs_oe_n, o_dqs_c, o_dqs_c_oe_n, // Strobe pair
	input wire logic o_rdqs, o_rdqs_oe_n, o_rdqs_c, o_rdqs_c_oe_n, o_term_dqs, // Redundant strobes, termination
	input wire logic o_cmd_valid, o_cmd_rank, // Command pulse and rank
	input dram_io_pkg::cmd_e o_cmd_code // Decoded command
);
	// ==========================================================
	// Command decode
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_sys_rst);
	// Link fields are held a whole CK period, so a fixed look-back is safe
	a_cmd_at_rise: assert property (o_cmd_valid |-> $past(i_ck, 2) && !$past(i_ck, 8))
		else $error("command not tied to a clock rise");
	a_cmd_fields: assert property (o_cmd_valid |-> o_cmd_code == $past({i_ras_n, i_cas_n, i_we_n}, 4)
		&& o_cmd_bank == $past(i_ba, 4) && o_cmd_addr == $past(i_addr, 4))
		else $error("command fields differ from the lines");
	a_cmd_select: assert property (o_cmd_valid |-> (o_cmd_rank ?
		$past(i_cs_n, 4) == 2'b01 && $past(i_cke[1], 4) : !$past(i_cs_n[0], 4) && $past(i_cke[0], 4)))
		else $error("command taken from a deselected rank");
	// ==========================================================
	// Termination
	a_term_rise: assert property ($rose(o_term_rank[0]) |-> $past(i_odt[0], 3))
		else $error("termination on without a request");
	a_term_balls: assert property (|o_term_rank |-> o_term_dqs
		&& o_term_dq == (i_org_x8 ? `TERM_X8 : `TERM_X4))
		else $error("termination on the wrong balls");
	a_term_off: assert property (o_term_rank == 2'b00 |-> o_term_dq == 8'h00 && !o_term_dqs)
		else $error("termination without an active rank");
	// ==========================================================
	// Read strobes and data width
	a_read_aligned: assert property (!o_dqs_oe_n && !$past(o_dqs_oe_n) && $stable(o_dqs) |-> $stable(o_dq))
		else $error("read data moved between strobe edges");
	a_dqs_c_pair: assert property (!o_dqs_c_oe_n |-> !o_dqs_oe_n && o_dqs_c != o_dqs)
		else $error("complement strobe not opposite to strobe");
	a_rdqs_read: assert property (!o_rdqs_oe_n |-> i_org_x8 && !o_dqs_oe_n && o_rdqs == o_dqs)
		else $error("redundant strobe outside an x8 read");
	a_rdqs_c_both: assert property (!o_rdqs_c_oe_n |-> !o_rdqs_oe_n && !o_dqs_c_oe_n)
		else $error("redundant complement without both modes");
	a_rdqs_c_pair: assert property (!o_rdqs_c_oe_n |-> o_rdqs_c != o_rdqs)
		else $error("redundant complement not opposite to strobe");
	a_x4_upper: assert property (!i_org_x8 |-> o_dq_oe_n[7:4] == 4'hf)
		else $error("upper data balls driven in x4");
endmodule : dram_io_checker

// ===== tb/ddr2_ctrl_model.sv
// Controller-side model: link clock, commands and write bursts
`timescale 1ns/1ps
module ddr2_ctrl_model
	import dram_io_pkg::*;
(
	input wire logic i_clk, // System clock, paces the link
	output logic o_ck, // Link clock true
	output logic o_ck_c, // Link clock complement
	output logic [1:0] o_cs_n, // Chip select per rank
	output logic [1:0] o_cke, // Clock enable per rank
	output logic [1:0] o_odt, // Termination request per rank
	output logic [2:0] o_cmd, // Row, column, write strobes
	output logic [2:0] o_ba, // Bank
	output logic [13:0] o_addr, // Address
	output logic [7:0] o_dq, // Write data
	output logic o_dqs, // Write strobe
	output logic o_dm // Write mask
);
	int cnt = 0;
	// ==========================================================
	// Free-running link clock, 32 system cycles a period
	initial begin
		{o_ck, o_cs_n, o_cke, o_odt} = {1'b0, 2'b11, 2'b11, 2'b00};
		{o_cmd, o_ba, o_addr} = {3'h7, 3'h0, 14'h0};
		{o_dq, o_dqs, o_dm} = 10'h0;
	end
	assign o_ck_c = ~o_ck;
	always @(negedge i_clk) begin
		cnt <= (cnt == 15) ? 0 : cnt + 1;
		if (cnt == 15) begin
			o_ck <= ~o_ck;
		end
	end
	// One command held across a full CK period, then deselect and scramble the bus
	task automatic cmd(input logic [1:0] cs, input logic [2:0] c, b, input logic [13:0] a);
		@(negedge o_ck);
		{o_cs_n, o_cmd, o_ba, o_addr} = {cs, c, b, a};
		@(negedge o_ck);
		{o_cs_n, o_cmd, o_ba, o_addr} = {2'b11, 3'h7, ~b, ~a};
	endtask : cmd
	// Write burst; in x4 the upper balls carry junk the device must ignore
	task automatic wr(input logic [1:0] cs, input logic [31:0] d, input logic [3:0] m, input bit x8);
		o_dqs = 1'b0;
		cmd(cs, CMD_WRITE, 3'h5, 14'h0);
		for (int k = 0; k < 4; k++) begin
			{o_dq, o_dm} = {x8 ? d[8*k+:8] : {~d[4*k+:4], d[4*k+:4]}, m[k]};
			// Each beat lasts half a link clock period, strobe edge in its middle
			repeat (8) @(negedge i_clk);
			o_dqs = ~o_dqs;
			repeat (8) @(negedge i_clk);
		end
		{o_dq, o_dm, o_dqs} = ~{o_dq, o_dm, o_dqs};
	endtask : wr
endmodule : ddr2_ctrl_model

// ===== tb/tb_top.sv
// Top testbench: dual-rank DDR2 ball interface against a controller model
`timescale 1ns/1ps
`include "dram_io_cfg.svh"
module tb_top;
	import dram_io_pkg::*;
	logic i_clk, i_sys_rst, i_org_x8, i_ck, i_ck_c, i_ras_n, i_cas_n, i_we_n, i_dqs, i_dm_rdqs, i_rd_valid;
	logic [1:0] i_cs_n, i_cke, i_odt, o_term_rank, o_rank_active;
	logic [2:0] i_ba, o_cmd_bank, cmd_w;
	logic [13:0] i_addr, o_cmd_addr;
	logic [7:0] i_dq, o_dq, o_dq_oe_n, o_term_dq, m_dq;
	logic o_dqs, o_dqs_oe_n, o_dqs_c, o_dqs_c_oe_n, o_rdqs, o_rdqs_oe_n, o_rdqs_c, o_rdqs_c_oe_n;
	logic o_term_dqs, o_term_dqs_c, o_term_dm, o_cmd_valid, o_cmd_rank, o_wr_valid, o_wr_rank, o_rd_ready;
	logic m_dqs, m_dm, dqs_p, oe_p;
	cmd_e o_cmd_code;
	logic [31:0] o_wr_data, i_rd_data;
	logic [3:0] o_wr_mask;
	logic [20:0] cmd_seen;
	logic [36:0] wr_seen;
	logic [10:0] rd_flags;
	logic [7:0] beats[$];
	int mismatches = 0;
	int n_tests = 0;
	int ncmd = 0;
	bit x8;

	dram_io_if uut (.*);
	ddr2_ctrl_model ctrl (.i_clk(i_clk), .o_ck(i_ck), .o_ck_c(i_ck_c), .o_cs_n(i_cs_n), .o_cke(i_cke),
		.o_odt(i_odt), .o_cmd(cmd_w), .o_ba(i_ba), .o_addr(i_addr), .o_dq(m_dq), .o_dqs(m_dqs), .o_dm(m_dm));
	// Ball levels: the device wins wherever it enables its driver
	assign {i_ras_n, i_cas_n, i_we_n} = cmd_w;
	assign i_dq = (o_dq_oe_n & m_dq) | (~o_dq_oe_n & o_dq);
	assign i_dqs = o_dqs_oe_n ? m_dqs : o_dqs;
	assign i_dm_rdqs = o_rdqs_oe_n ? m_dm : o_rdqs;
	initial begin
		i_clk = 1'b0;
		forever #2.5 i_clk = ~i_clk;
	end
	// ==========================================================
	// Capture what the block shows: commands, write words, read beats
	always @(posedge i_clk) begin
		if (o_cmd_valid) begin
			ncmd++;
			cmd_seen = {o_cmd_code, o_cmd_rank, o_cmd_bank, o_cmd_addr};
		end
		if (o_wr_valid) begin
			wr_seen = {o_wr_data, o_wr_mask, o_wr_rank};
		end
		if (o_dqs_oe_n === 1'b0 && (oe_p || o_dqs !== dqs_p)) begin
			beats.push_back(o_dq);
			rd_flags = {o_dq_oe_n, o_dqs_c_oe_n, o_rdqs_oe_n, o_rdqs_c_oe_n};
		end
		{oe_p, dqs_p} = {o_dqs_oe_n, o_dqs};
	end
	// ==========================================================
	// Shared helpers
	task automatic check(input logic [63:0] got, exp);
		n_tests++;
		if (got !== exp) begin
			mismatches++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check
	task automatic idle(input int n);
		repeat (n) @(negedge i_clk);
	endtask : idle
	// Mode bits live per rank, so both ranks are loaded
	task automatic emr(input logic [13:0] a);
		ctrl.cmd(2'b10, CMD_LOAD_MODE, `BA_EMR, a);
		ctrl.cmd(2'b01, CMD_LOAD_MODE, `BA_EMR, a);
	endtask : emr
	// ==========================================================
	// Scenarios
	task automatic t_cmd;
		logic [2:0] codes[5] = '{CMD_REFRESH, CMD_PRECHARGE, CMD_ACTIVATE, CMD_TERMINATE, CMD_NOP};
		int n;
		foreach (codes[i]) begin
			for (int r = 0; r < 2; r++) begin
				n = ncmd;
				ctrl.cmd(r ? 2'b01 : 2'b10, codes[i], 3'(i + r), 14'h2a5c ^ 14'(i));
				check(ncmd - n, 1);
				check(cmd_seen, {codes[i], r[0], 3'(i + r), 14'h2a5c ^ 14'(i)});
			end
		end
		n = ncmd;
		ctrl.cmd(2'b11, CMD_ACTIVATE, 3'h0, 14'h0);
		ctrl.o_cke = 2'b10;
		idle(64);
		check(o_rank_active, 2'b10);
		ctrl.cmd(2'b10, CMD_ACTIVATE, 3'h0, 14'h0);
		ctrl.o_cke = 2'b11;
		check(ncmd - n, 0);
	endtask : t_cmd
	task automatic t_odt;
		emr(x8 ? 14'h0004 : 14'h0040);
		ctrl.o_odt = 2'b01;
		idle(64);
		check({o_term_rank, o_term_dq, o_term_dqs, o_term_dqs_c, o_term_dm}, {2'b01, x8 ? `TERM_X8 : `TERM_X4, 3'h7});
		// Complement strobe off and, in x8, redundant strobe on: those balls drop out of termination
		emr(14'h0c04);
		ctrl.o_odt = 2'b10;
		idle(64);
		check({o_term_rank, o_term_dqs_c, o_term_dm}, {2'b10, 1'b0, !x8});
		ctrl.o_odt = 2'b00;
		idle(64);
		check(o_term_rank, 2'b00);
		emr(14'h0000);
		ctrl.o_odt = 2'b11;
		idle(64);
		check({o_term_rank, o_term_dq}, 10'h0);
		ctrl.o_odt = 2'b00;
	endtask : t_odt
	// Second pass enables the redundant strobe, which turns the mask ball off in x8
	task automatic t_wr;
		logic [31:0] d;
		for (int i = 0; i < 2; i++) begin
			d = i ? 32'h6e17_a94c : 32'h9ac3_5e71;
			emr(i ? 14'h0800 : 14'h0000);
			ctrl.wr(2'b01, d, 4'b0100, x8);
			idle(8);
			check(wr_seen, {x8 ? d : {16'h0, d[15:0]}, (i && x8) ? 4'h0 : 4'b0100, 1'b1});
		end
	endtask : t_wr
	// Fill the read buffer with no READ pending, then drain it; modes change halfway
	task automatic t_rd;
		int n;
		logic [31:0] w;
		emr(14'h0800);
		for (n = 0; n < 40 && o_rd_ready === 1'b1; n++) begin
			{i_rd_valid, i_rd_data} = {1'b1, 32'h7654_3210 + 32'(n) * 32'h0101_0101};
			idle(1);
			i_rd_valid = 1'b0;
			idle(1);
		end
		check(n, 32);
		for (int i = 0; i < 32; i++) begin
			if (i == 16) begin
				emr(14'h0400);
			end
			w = 32'h7654_3210 + 32'(i) * 32'h0101_0101;
			beats.delete();
			ctrl.cmd(2'b10, CMD_READ, 3'h0, 14'(i));
			idle(96);
			check(beats.size(), 4);
			foreach (beats[k]) check(beats[k] & (x8 ? 8'hff : 8'h0f), x8 ? w[8*k+:8] : w[4*k+:4]);
			check(rd_flags, {x8 ? `OE_X8 : `OE_X4, i >= 16, {2{!(x8 && i < 16)}}});
		end
	endtask : t_rd
	// ==========================================================
	// Verdict
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : wrap_up
	// Both organizations, each from a fresh reset
	initial begin
		{i_sys_rst, i_org_x8, i_rd_valid, i_rd_data, oe_p, dqs_p} = {3'b110, 32'h0, 2'b10};
		for (int o = 1; o >= 0; o--) begin
			{x8, i_org_x8, i_sys_rst} = {o[0], o[0], 1'b1};
			idle(4);
			i_sys_rst = 1'b0;
			idle(2);
			check({o_dq_oe_n, o_rd_ready, o_cmd_valid}, {`OE_OFF, 2'b10});
			idle(6);
			t_cmd();
			t_odt();
			t_wr();
			t_rd();
		end
		wrap_up();
	end
	// Watchdog: a run takes about 13k cycles
	initial begin
		#400us;
		mismatches++;
		wrap_up();
	end
endmodule : tb_top
bind dram_io_if dram_io_checker chk (.*);
